/* File: include/epcr_defines.svh */
// Purpose: constants of the ethernet port control register bank
// Assumes: 16-bit registers at byte offsets, 25 MHz clock
// Notes: offsets are the printed byte offsets
// Notes on behaviour
// - master enable: low byte zero enables, pattern 0000_01xx disables, reset disabled
// - eeprom command: word address bits 7:0, opcode bits 9:8
// - eeprom data word, low byte at even address, high byte next
// - receive byte counter counts bytes of the current frame as they arrive
// - enabled event sets source bits, shows them in queue, raises irq
// - queue sources: receive, transmit, buffer events, missed and collision counters
// - queue word: register number in 5:0, contents in 15:6
// - queue also readable at alias offset 0008h
// - receive configuration reads 000011 in bits 5:0
// - skip bit deletes last committed frame once per write unless dma-only
// - good-frame enable interrupts on error-free frames unless dma-only
// - keep-fcs bit stores and counts the four crc bytes
// - crc-error enable interrupts on bad crc frames
// - short-frame enable interrupts on frames under 64 bytes
// - frames under eight bytes are always discarded
// - oversize enable interrupts on frames over 1518 bytes, any crc
// - configuration defaults at reset, may be loaded from eeprom
// - receive event register clears when read
`ifndef EPCR_DEFINES_SVH
`define EPCR_DEFINES_SVH
`define EPCR_OFF_QUEUE_ALIAS 12'h008
`define EPCR_OFF_MASTER_IE 12'h022
`define EPCR_OFF_EE_CMD 12'h040
`define EPCR_OFF_EE_DATA 12'h042
`define EPCR_OFF_RX_COUNT 12'h050
`define EPCR_OFF_RX_CFG 12'h102
`define EPCR_OFF_QUEUE 12'h120
`define EPCR_OFF_RX_EVENT 12'h124
`define EPCR_NUM_RX_CFG 6'h03
`define EPCR_NUM_RX_EVENT 6'h04
`define EPCR_NUM_TX_EVENT 6'h08
`define EPCR_NUM_BUF_EVENT 6'h0C
`define EPCR_NUM_MISSED 6'h10
`define EPCR_NUM_COLL 6'h12
`define EPCR_MASTER_IE_RESET 16'h0004
`define EPCR_RX_CFG_RESET 10'h000
`define EPCR_CFG_SKIP 6
`define EPCR_CFG_GOOD_IE 8
`define EPCR_CFG_DMA_ONLY 9
`define EPCR_CFG_KEEP_FCS 11
`define EPCR_CFG_FCS_IE 12
`define EPCR_CFG_SHORT_IE 13
`define EPCR_CFG_OVER_IE 14
`define EPCR_EV_GOOD 2
`define EPCR_EV_FCS 6
`define EPCR_EV_SHORT 7
`define EPCR_EV_OVER 8
`define EPCR_MIN_FRAME 16'd64
`define EPCR_MAX_FRAME 16'd1518
`define EPCR_DISCARD_LEN 16'd8
`define EPCR_FCS_BYTES 16'd4
`endif

/* File: include/epcr_pkg.sv */
package epcr_pkg;
    typedef struct packed {
        logic [11:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } epcr_bus_t;
    typedef struct packed {
        logic start;
        logic byte_ok;
        logic done;
        logic fcs_bad;
        logic dribble;
    } epcr_rx_t;
    typedef struct packed {
        logic valid;
        logic [5:0] num;
        logic [9:0] payload;
    } epcr_src_t;
endpackage

/* File: logic/epcr_frame_meter.sv */
// Purpose: counts bytes of the frame in flight and classifies it at its end
// Assumes: fcs bytes are the last four counted
// Notes: the length result is held until the next frame ends
`timescale 1ns/100ps
`include "epcr_defines.svh"
module epcr_frame_meter (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire epcr_pkg::epcr_rx_t rx_i,
    input wire logic keep_fcs_i,
    output logic [15:0] count_o,
    output logic [15:0] length_o,
    output logic done_o,
    output logic is_short_o,
    output logic is_over_o,
    output logic is_tiny_o
);
    logic [15:0] total;
    always_comb begin
        total = count_o + (rx_i.byte_ok ? 16'h0001 : 16'h0000);
    end
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            count_o <= 16'h0000;
        end else if (rx_i.start) begin
            count_o <= 16'h0000;
        end else if (rx_i.byte_ok) begin
            count_o <= count_o + 16'h0001;
        end
    end
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            length_o <= 16'h0000;
            done_o <= 1'b0;
            is_short_o <= 1'b0;
            is_over_o <= 1'b0;
            is_tiny_o <= 1'b0;
        end else begin
            done_o <= rx_i.done;
            if (rx_i.done) begin
                length_o <= keep_fcs_i ? total :
                    (total > `EPCR_FCS_BYTES ? total - `EPCR_FCS_BYTES : 16'h0000);
                is_short_o <= total < `EPCR_MIN_FRAME;
                is_over_o <= total > `EPCR_MAX_FRAME;
                is_tiny_o <= total < `EPCR_DISCARD_LEN;
            end
        end
    end
endmodule

/* File: logic/epcr_queue_pick.sv */
// Purpose: picks the pending source with the lowest register number
// Assumes: sources hold their contents until read
// Notes: fixed priority; a busy receive side can starve later sources
`timescale 1ns/100ps
module epcr_queue_pick (
    input wire epcr_pkg::epcr_src_t [4:0] src_i,
    output logic [15:0] word_o,
    output logic [2:0] index_o,
    output logic any_o
);
    always_comb begin
        word_o = 16'h0000;
        index_o = 3'h0;
        any_o = 1'b0;
        for (int i = 4; i >= 0; i--) begin
            if (src_i[i].valid) begin
                word_o = {src_i[i].payload, src_i[i].num};
                index_o = 3'(i);
                any_o = 1'b1;
            end
        end
    end
endmodule

/* File: logic/epcr_regs.sv */
// Purpose: host registers of the ethernet port: enable, eeprom, counters, queue
// Assumes: one-cycle strobes, read data the cycle after the read strobe
// Notes: eeprom sequencing and the transmit side live elsewhere
//
// Added by the designer: the plain strobed port.
`timescale 1ns/100ps
`include "epcr_defines.svh"
module epcr_regs (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic [11:0] addr_i,
    input wire logic [15:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [15:0] rdata_o,
    input wire epcr_pkg::epcr_rx_t rx_i,
    input wire logic [9:0] tx_event_i,
    input wire logic [9:0] buf_event_i,
    input wire logic missed_ovf_i,
    input wire logic coll_ovf_i,
    input wire logic eeprom_present_i,
    input wire logic eeprom_cfg_valid_i,
    input wire logic [9:0] eeprom_cfg_i,
    output logic irq_o,
    output logic [7:0] eeprom_word_address_o,
    output logic [1:0] eeprom_opcode_o,
    output logic eeprom_cmd_stb_o,
    output logic [15:0] eeprom_data_word_o,
    output logic skip_frame_o,
    output logic keep_fcs_o,
    output logic dma_only_receive_o,
    output logic discard_frame_o,
    output logic [15:0] frame_length_o
);
    logic [15:0] master_interrupt_enable;
    logic [15:0] eeprom_command;
    logic [9:0] receive_configuration;
    logic [9:0] receive_event_flags;
    logic [9:0] transmit_event_flags;
    logic [9:0] buffer_event_flags;
    logic [9:0] missed_frame_counter;
    logic [9:0] collision_counter;
    logic [15:0] rx_count;
    logic [15:0] rx_length;
    logic meter_done;
    logic is_short;
    logic is_over;
    logic is_tiny;
    logic [15:0] queue_word;
    logic [2:0] queue_index;
    logic queue_any;
    logic cfg_loaded;
    logic irq_enabled;
    logic queue_read;
    logic [15:0] next_rdata;
    logic [9:0] rx_set;
    logic frame_fcs_bad;
    logic frame_dribble;
    epcr_pkg::epcr_src_t [4:0] sources;

    function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
        hit = a == off;
    endfunction

    // flags that hardware sets and a read clears: set wins the tie
    function automatic logic [9:0] upd(input logic [9:0] cur, input logic [9:0] set, input logic clr);
        upd = (clr ? 10'h000 : cur) | set;
    endfunction

    epcr_frame_meter meter (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .rx_i(rx_i),
        .keep_fcs_i(receive_configuration[`EPCR_CFG_KEEP_FCS - 6]),
        .count_o(rx_count),
        .length_o(rx_length),
        .done_o(meter_done),
        .is_short_o(is_short),
        .is_over_o(is_over),
        .is_tiny_o(is_tiny)
    );

    // enable pattern has bit 2 clear and the low byte zero
    assign irq_enabled = master_interrupt_enable[7:0] == 8'h00;
    assign queue_read = rd_i && (hit(addr_i, `EPCR_OFF_QUEUE) || hit(addr_i, `EPCR_OFF_QUEUE_ALIAS));

    always_comb begin
        sources[0] = '{valid: receive_event_flags != 10'h000, num: `EPCR_NUM_RX_EVENT,
            payload: receive_event_flags};
        sources[1] = '{valid: transmit_event_flags != 10'h000, num: `EPCR_NUM_TX_EVENT,
            payload: transmit_event_flags};
        sources[2] = '{valid: buffer_event_flags != 10'h000, num: `EPCR_NUM_BUF_EVENT,
            payload: buffer_event_flags};
        sources[3] = '{valid: missed_frame_counter != 10'h000, num: `EPCR_NUM_MISSED,
            payload: missed_frame_counter};
        sources[4] = '{valid: collision_counter != 10'h000, num: `EPCR_NUM_COLL,
            payload: collision_counter};
    end

    epcr_queue_pick pick (
        .src_i(sources),
        .word_o(queue_word),
        .index_o(queue_index),
        .any_o(queue_any)
    );

    // fcs and dribble are valid only beside done; held for the meter result cycle
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            frame_fcs_bad <= 1'b0;
            frame_dribble <= 1'b0;
        end else if (rx_i.done) begin
            frame_fcs_bad <= rx_i.fcs_bad;
            frame_dribble <= rx_i.dribble;
        end
    end

    // frame end classification feeds receive event bits
    always_comb begin
        rx_set = 10'h000;
        if (meter_done && !is_tiny) begin
            if (!receive_configuration[`EPCR_CFG_DMA_ONLY - 6] && !frame_fcs_bad && !is_short && !is_over
                && receive_configuration[`EPCR_CFG_GOOD_IE - 6]) begin
                rx_set[`EPCR_EV_GOOD] = 1'b1;
            end
            if (frame_fcs_bad && receive_configuration[`EPCR_CFG_FCS_IE - 6]) begin
                rx_set[`EPCR_EV_FCS] = 1'b1;
            end
            if (is_short && receive_configuration[`EPCR_CFG_SHORT_IE - 6]) begin
                rx_set[`EPCR_EV_SHORT] = 1'b1;
            end
            if (is_over && receive_configuration[`EPCR_CFG_OVER_IE - 6]) begin
                rx_set[`EPCR_EV_OVER] = 1'b1;
            end
            rx_set[1] = frame_dribble && (frame_fcs_bad || is_short || is_over);
        end
    end

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            master_interrupt_enable <= `EPCR_MASTER_IE_RESET;
        end else if (wr_i && hit(addr_i, `EPCR_OFF_MASTER_IE)) begin
            master_interrupt_enable <= {8'h00, wdata_i[7:0]};
        end
    end

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            eeprom_command <= 16'h0000;
            eeprom_data_word_o <= 16'h0000;
            eeprom_cmd_stb_o <= 1'b0;
        end else begin
            eeprom_cmd_stb_o <= wr_i && hit(addr_i, `EPCR_OFF_EE_CMD);
            if (wr_i && hit(addr_i, `EPCR_OFF_EE_CMD)) begin
                // upper bits kept as written; software keeps them zero
                eeprom_command <= wdata_i;
            end
            if (wr_i && hit(addr_i, `EPCR_OFF_EE_DATA)) begin
                eeprom_data_word_o <= wdata_i;
            end
        end
    end

    always_comb begin
        eeprom_word_address_o = eeprom_command[7:0];
        eeprom_opcode_o = eeprom_command[9:8];
    end

    // configuration: default at reset, one eeprom load if a part is fitted
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            receive_configuration <= `EPCR_RX_CFG_RESET;
            cfg_loaded <= 1'b0;
            skip_frame_o <= 1'b0;
        end else begin
            skip_frame_o <= 1'b0;
            if (wr_i && hit(addr_i, `EPCR_OFF_RX_CFG)) begin
                // skip is act-once and never stored
                receive_configuration <= {wdata_i[15:7], 1'b0};
                skip_frame_o <= wdata_i[`EPCR_CFG_SKIP] && !receive_configuration[`EPCR_CFG_DMA_ONLY - 6];
                cfg_loaded <= 1'b1;
            end else if (!cfg_loaded && eeprom_present_i && eeprom_cfg_valid_i) begin
                receive_configuration <= {eeprom_cfg_i[9:1], 1'b0};
                cfg_loaded <= 1'b1;
            end
        end
    end

    // event sources: queue read clears the shown source
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            receive_event_flags <= 10'h000;
            transmit_event_flags <= 10'h000;
            buffer_event_flags <= 10'h000;
            missed_frame_counter <= 10'h000;
            collision_counter <= 10'h000;
        end else begin
            receive_event_flags <= upd(receive_event_flags, rx_set,
                (queue_read && queue_any && queue_index == 3'h0) ||
                (rd_i && hit(addr_i, `EPCR_OFF_RX_EVENT)));
            transmit_event_flags <= upd(transmit_event_flags, tx_event_i,
                queue_read && queue_any && queue_index == 3'h1);
            buffer_event_flags <= upd(buffer_event_flags, buf_event_i,
                queue_read && queue_any && queue_index == 3'h2);
            missed_frame_counter <= upd(missed_frame_counter, {9'h000, missed_ovf_i},
                queue_read && queue_any && queue_index == 3'h3);
            collision_counter <= upd(collision_counter, {9'h000, coll_ovf_i},
                queue_read && queue_any && queue_index == 3'h4);
        end
    end

    // irq follows pending sources; low once all are read
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= irq_enabled && (receive_event_flags != 10'h000 || transmit_event_flags != 10'h000
                || buffer_event_flags != 10'h000 || missed_frame_counter != 10'h000
                || collision_counter != 10'h000);
        end
    end

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            keep_fcs_o <= 1'b0;
            dma_only_receive_o <= 1'b0;
            discard_frame_o <= 1'b0;
            frame_length_o <= 16'h0000;
        end else begin
            keep_fcs_o <= receive_configuration[`EPCR_CFG_KEEP_FCS - 6];
            dma_only_receive_o <= receive_configuration[`EPCR_CFG_DMA_ONLY - 6];
            discard_frame_o <= meter_done && is_tiny;
            frame_length_o <= rx_length;
        end
    end

    always_comb begin
        next_rdata = 16'h0000;
        case (addr_i)
            `EPCR_OFF_MASTER_IE: next_rdata = master_interrupt_enable;
            `EPCR_OFF_EE_CMD: next_rdata = eeprom_command;
            `EPCR_OFF_EE_DATA: next_rdata = eeprom_data_word_o;
            `EPCR_OFF_RX_COUNT: next_rdata = rx_count;
            `EPCR_OFF_RX_CFG: next_rdata = {receive_configuration, `EPCR_NUM_RX_CFG};
            `EPCR_OFF_QUEUE: next_rdata = queue_word;
            `EPCR_OFF_QUEUE_ALIAS: next_rdata = queue_word;
            `EPCR_OFF_RX_EVENT: next_rdata = {receive_event_flags, `EPCR_NUM_RX_EVENT};
            default: next_rdata = 16'h0000;
        endcase
    end

    // read data only in the cycle after the strobe
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            rdata_o <= 16'h0000;
        end else begin
            rdata_o <= rd_i ? next_rdata : 16'h0000;
        end
    end
endmodule

/* File: tb/epcr_frame_src.sv */
// Purpose: receive datapath stand-in that plays one frame per request
// Assumes: fcs bytes are sent as the last four byte strobes
// Notes: fcs flag shows its inverse outside the done cycle on purpose
`timescale 1ns/100ps
module epcr_frame_src (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic go_i,
    input wire logic [15:0] len_i,
    input wire logic bad_i,
    output epcr_pkg::epcr_rx_t rx_o,
    output logic busy_o
);
    logic [15:0] left;
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            rx_o <= '0;
            left <= 16'h0000;
            busy_o <= 1'h0;
        end else begin
            rx_o.start <= go_i && !busy_o;
            rx_o.byte_ok <= busy_o && left != 16'h0000;
            rx_o.done <= busy_o && left == 16'h0000;
            // flag only meaningful with done, so it wanders elsewhere
            rx_o.fcs_bad <= (busy_o && left == 16'h0000) ? bad_i : !bad_i;
            rx_o.dribble <= 1'h0;
            if (go_i && !busy_o) begin
                busy_o <= 1'h1;
                left <= len_i;
            end else if (busy_o && left != 16'h0000) begin
                left <= left - 16'h0001;
            end else begin
                busy_o <= 1'h0;
            end
        end
    end
endmodule

/* File: tb/epcr_regs_assertions.sv */
// Purpose: port-level checks of the register bank
// Assumes: one clock, reset active high
// Notes: no check on event ordering under concurrent sets
`timescale 1ns/100ps
`include "epcr_defines.svh"
module epcr_regs_assertions (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic [11:0] addr_i,
    input wire logic [15:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [15:0] rdata_o,
    input wire logic irq_o,
    input wire logic [7:0] eeprom_word_address_o,
    input wire logic [1:0] eeprom_opcode_o,
    input wire logic eeprom_cmd_stb_o,
    input wire logic [15:0] eeprom_data_word_o,
    input wire logic skip_frame_o,
    input wire logic keep_fcs_o,
    input wire logic dma_only_receive_o,
    input wire logic discard_frame_o
);
    default clocking @(posedge clk_i);
    endclocking
    default disable iff (reset_i);
    logic [15:0] wd_q;
    logic [15:0] wd_qq;
    logic q_rd;
    logic cfg_wr;
    logic skip_wr;
    always_ff @(posedge clk_i) begin
        wd_q <= wdata_i;
        wd_qq <= wd_q;
    end
    assign q_rd = rd_i && (addr_i == `EPCR_OFF_QUEUE || addr_i == `EPCR_OFF_QUEUE_ALIAS);
    assign cfg_wr = wr_i && addr_i == `EPCR_OFF_RX_CFG;
    assign skip_wr = cfg_wr && wdata_i[`EPCR_CFG_SKIP];
    a_cfg_ident: assert property (
        rd_i && addr_i == `EPCR_OFF_RX_CFG |=> rdata_o[5:0] == `EPCR_NUM_RX_CFG) else $error("config id wrong");
    a_queue_number: assert property (
        q_rd |=> rdata_o[5:0] inside {6'h00, 6'h04, 6'h08, 6'h0C, 6'h10, 6'h12}) else $error("queue number bad");
    a_queue_empty: assert property (
        q_rd ##1 rdata_o[5:0] == 6'h00 |-> rdata_o == 16'h0000 ##1 !irq_o) else $error("empty queue wrong");
    a_cmd_fields: assert property (
        wr_i && addr_i == `EPCR_OFF_EE_CMD |=> eeprom_word_address_o == wd_q[7:0] && eeprom_opcode_o == wd_q[9:8])
        else $error("command fields wrong");
    a_cmd_strobe: assert property (
        wr_i && addr_i == `EPCR_OFF_EE_CMD |-> ##[1:2] eeprom_cmd_stb_o) else $error("command strobe missing");
    a_data_word: assert property (
        wr_i && addr_i == `EPCR_OFF_EE_DATA |=> eeprom_data_word_o == wd_q) else $error("data word wrong");
    a_skip_single: assert property (
        skip_frame_o |-> $past(skip_wr)) else $error("skip without its own write");
    a_skip_cause: assert property (
        cfg_wr && wdata_i[6] && !wdata_i[9] && !dma_only_receive_o |-> ##[1:2] skip_frame_o)
        else $error("skip not issued");
    a_cfg_levels: assert property (
        cfg_wr |-> ##2 keep_fcs_o == wd_qq[11] && dma_only_receive_o == wd_qq[9]) else $error("config levels wrong");
    a_discard_single: assert property (
        discard_frame_o |=> !discard_frame_o) else $error("discard longer than one cycle");
    c_irq: cover property ($rose(irq_o));
    c_skip: cover property (skip_frame_o);
    c_discard: cover property (discard_frame_o);
    c_queue: cover property (q_rd ##1 rdata_o != 16'h0000);
endmodule
bind epcr_regs epcr_regs_assertions i_epcr_regs_assertions (.clk_i(clk_i), .reset_i(reset_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .irq_o(irq_o),
    .eeprom_word_address_o(eeprom_word_address_o), .eeprom_opcode_o(eeprom_opcode_o),
    .eeprom_cmd_stb_o(eeprom_cmd_stb_o), .eeprom_data_word_o(eeprom_data_word_o), .skip_frame_o(skip_frame_o),
    .keep_fcs_o(keep_fcs_o), .dma_only_receive_o(dma_only_receive_o), .discard_frame_o(discard_frame_o));

/* File: tb/test_ethernet_port_control_regs.sv */
// Purpose: directed bench of the ethernet port register bank
// Assumes: read data checked one cycle after the strobe
// Notes: master enable left on between scenarios
`timescale 1ns/100ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin num_errors++; \
    $display("MISMATCH t=%0t got %h expected %h", $time, g, e); end end
module test_ethernet_port_control_regs;
logic clk_i, reset_i, wr_i, rd_i, go, bad, busy, eeprom_present_i, eeprom_cfg_valid_i, missed_ovf_i, coll_ovf_i;
logic [11:0] addr_i;
logic [15:0] wdata_i, rdata_o, len, eeprom_data_word_o, frame_length_o;
logic [9:0] tx_event_i, buf_event_i, eeprom_cfg_i;
logic irq_o, eeprom_cmd_stb_o, skip_frame_o, keep_fcs_o, dma_only_receive_o, discard_frame_o;
logic [7:0] eeprom_word_address_o;
logic [1:0] eeprom_opcode_o;
epcr_pkg::epcr_rx_t rx_i;
int num_errors = 0, comparisons = 0, skips = 0, drops = 0;
epcr_regs i_epcr_regs (.clk_i(clk_i), .reset_i(reset_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .rx_i(rx_i), .tx_event_i(tx_event_i), .buf_event_i(buf_event_i),
    .missed_ovf_i(missed_ovf_i), .coll_ovf_i(coll_ovf_i), .eeprom_present_i(eeprom_present_i),
    .eeprom_cfg_valid_i(eeprom_cfg_valid_i), .eeprom_cfg_i(eeprom_cfg_i), .irq_o(irq_o),
    .eeprom_word_address_o(eeprom_word_address_o), .eeprom_opcode_o(eeprom_opcode_o),
    .eeprom_cmd_stb_o(eeprom_cmd_stb_o), .eeprom_data_word_o(eeprom_data_word_o), .skip_frame_o(skip_frame_o),
    .keep_fcs_o(keep_fcs_o), .dma_only_receive_o(dma_only_receive_o), .discard_frame_o(discard_frame_o),
    .frame_length_o(frame_length_o));
epcr_frame_src i_epcr_frame_src (.clk_i(clk_i), .reset_i(reset_i), .go_i(go), .len_i(len), .bad_i(bad),
    .rx_o(rx_i), .busy_o(busy));
initial begin
    clk_i = 1'h0;
    forever #20 clk_i = ~clk_i;
end
always @(posedge clk_i) begin
    skips += (skip_frame_o === 1'h1);
    drops += (discard_frame_o === 1'h1);
end
task automatic wr(input logic [11:0] a, input logic [15:0] v);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= v;
    wr_i <= 1'h1;
    @(posedge clk_i);
    wr_i <= 1'h0;
    #1;
endtask
task automatic rd(input logic [11:0] a, input logic [15:0] e);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'h1;
    @(posedge clk_i);
    rd_i <= 1'h0;
    #1 `CHK(rdata_o, e)
endtask
task automatic frame(input logic [15:0] l, input logic b);
    @(posedge clk_i);
    go <= 1'h1;
    len <= l;
    bad <= b;
    @(posedge clk_i);
    go <= 1'h0;
    #1;
    for (int i = 0; i < 2000 && busy; i++) begin
        @(posedge clk_i);
        #1;
    end
    `CHK(busy, 1'h0)
    repeat (4) @(posedge clk_i);
    #1;
endtask
task automatic ev(input logic [9:0] t, input logic [9:0] b, input logic m);
    @(posedge clk_i);
    tx_event_i <= t;
    buf_event_i <= b;
    missed_ovf_i <= m;
    coll_ovf_i <= m;
    @(posedge clk_i);
    tx_event_i <= 10'h000;
    buf_event_i <= 10'h000;
    missed_ovf_i <= 1'h0;
    coll_ovf_i <= 1'h0;
    repeat (3) @(posedge clk_i);
    #1;
endtask
task automatic t_reset;
    rd(12'h022, 16'h0004);
    rd(12'h120, 16'h0000);
    rd(12'h102, 16'h0003);
    `CHK(irq_o, 1'h0)
endtask
task automatic t_load;
    // no part fitted: the offered word is ignored; then a fitted part loads it
    for (int p = 0; p < 2; p++) begin
        @(posedge clk_i);
        eeprom_present_i <= 1'(p);
        eeprom_cfg_valid_i <= 1'h1;
        eeprom_cfg_i <= 10'h004;
        @(posedge clk_i);
        eeprom_cfg_valid_i <= 1'h0;
        rd(12'h102, p == 0 ? 16'h0003 : 16'h0103);
    end
endtask
task automatic t_eeprom;
    wr(12'h040, 16'h0255);
    `CHK({eeprom_opcode_o, eeprom_word_address_o}, 10'h255)
    wr(12'h042, 16'hA55A);
    rd(12'h042, 16'hA55A);
    `CHK(eeprom_data_word_o, 16'hA55A)
endtask
task automatic t_good;
    wr(12'h022, 16'h0000);
    frame(16'h0046, 1'h0);
    `CHK(irq_o, 1'h1)
    rd(12'h050, 16'h0046);
    `CHK(frame_length_o, 16'h0042)
    rd(12'h120, 16'h0104);
    rd(12'h120, 16'h0000);
    `CHK(irq_o, 1'h0)
endtask
task automatic t_keep;
    wr(12'h102, 16'h0800);
    @(posedge clk_i);
    #1 `CHK(keep_fcs_o, 1'h1)
    frame(16'h0046, 1'h0);
    `CHK(frame_length_o, 16'h0046)
endtask
task automatic t_errors;
    // bad fcs, short, then oversize with bad fcs; one enable each
    for (int k = 0; k < 3; k++) begin
        wr(12'h102, 16'h1000 << k);
        frame(k == 0 ? 16'h0046 : k == 1 ? 16'h0028 : 16'h05EF, k != 1);
        rd(12'h120, (16'h1000 << k) | 16'h0004);
    end
endtask
task automatic t_clear;
    wr(12'h102, 16'h0100);
    frame(16'h0046, 1'h0);
    rd(12'h124, 16'h0104);
    rd(12'h120, 16'h0000);
endtask
task automatic t_tiny;
    wr(12'h102, 16'h2000);
    frame(16'h0005, 1'h0);
    `CHK(drops, 1)
    rd(12'h120, 16'h0000);
endtask
task automatic t_dma;
    wr(12'h102, 16'h0300);
    @(posedge clk_i);
    #1 `CHK(dma_only_receive_o, 1'h1)
    frame(16'h0046, 1'h0);
    `CHK(irq_o, 1'h0)
    rd(12'h120, 16'h0000);
endtask
task automatic t_skip;
    // leave dma-only first: skip is not used while it is selected
    wr(12'h102, 16'h0000);
    wr(12'h102, 16'h0040);
    wr(12'h102, 16'h0040);
    wr(12'h102, 16'h0000);
    `CHK(skips, 2)
endtask
task automatic t_queue;
    ev(10'h001, 10'h002, 1'h1);
    `CHK(irq_o, 1'h1)
    rd(12'h008, 16'h0048);
    rd(12'h120, 16'h008C);
    rd(12'h120, 16'h0050);
    rd(12'h120, 16'h0052);
    rd(12'h120, 16'h0000);
endtask
task automatic t_mask;
    wr(12'h022, 16'h0004);
    ev(10'h008, 10'h000, 1'h0);
    `CHK(irq_o, 1'h0)
    wr(12'h022, 16'h0000);
    repeat (2) @(posedge clk_i);
    #1 `CHK(irq_o, 1'h1)
    rd(12'h120, 16'h0208);
endtask
task automatic wrap_up;
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) begin
        $display("All checks passed");
    end else begin
        $display("Checks failed");
    end
    $finish;
endtask
initial begin
    #800000;
    num_errors++;
    wrap_up();
end
initial begin
    {reset_i, eeprom_present_i} = 2'h2;
    {wr_i, rd_i, go, bad, eeprom_cfg_valid_i, missed_ovf_i, coll_ovf_i} = 7'h00;
    {addr_i, wdata_i, len} = 44'h0;
    {tx_event_i, buf_event_i, eeprom_cfg_i} = 30'h0;
    repeat (4) @(posedge clk_i);
    reset_i <= 1'h0;
    t_reset();
    t_load();
    t_eeprom();
    t_good();
    t_keep();
    t_errors();
    t_clear();
    t_tiny();
    t_dma();
    t_skip();
    t_queue();
    t_mask();
    wrap_up();
end
endmodule
